// *** design/scoc_top.sv ***
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module scoc_top
   import scoc_pkg::*;
#(
   parameter int FULL_INSTANCE = 1,   // 1: six outputs, dead time, modes
   parameter int CELL_SEL      = 1    // which logic cell feeds source 5 (0 none)
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // time base side (same clock)
   input  wire logic        tb_rollover,
   input  wire logic        trigger_mode_enable,
   input  wire logic        timer_triggered,
   input  wire logic        cap_cmp_event,
   input  wire logic        timer_mode,
   input  wire logic        mode_aux_sig,
   input  wire logic        pwm_a,
   input  wire logic        pwm_b,
   // asynchronous sources
   input  wire logic [2:0]  cmp_out,
   input  wire logic        logic_cell_one_out,
   input  wire logic        logic_cell_two_out,
   input  wire logic        output_fault_a,
   input  wire logic        output_fault_b,
   input  wire logic        capture_input_pin,
   // outputs
   output logic [5:0]       pin_out,
   output logic [5:0]       pin_oe,
   output logic             aux_out,
   output logic             capture_signal,
   output logic             capture_disable_flag,
   output logic             shutdown_event_flag,
   output logic [5:0]       dead_time_count,
   output logic [2:0]       one_shot_extend_count,
   output logic [2:0]       output_mode_select
);
   initial begin
      if (FULL_INSTANCE > 1 || CELL_SEL > 2) $error("scoc_top: bad parameter");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [15:0] sdg;
      logic [15:0] oec;
      logic [15:0] dtc;
      logic [15:0] mpc;
      logic [5:0]  oe_live;
      scoc_sd_e    sd;
      logic        cap_dis;
      logic        arm;
      logic        gate_d;
      logic        trig_seen;
      logic [15:0] rdata;
      logic [5:0]  pin_out;
      logic [5:0]  pin_oe;
      logic        aux;
      logic        cap_sig;
      logic [10:0] s1;   // first sync stage: cell two, cell one, capture pin, sources 7-0
      logic [10:0] s2;   // second sync stage, the only one that logic reads
   } scoc_state_s;

   scoc_state_s st_reg, st_next;

   function automatic logic [15:0] wmask(input logic [2:0] a);
      logic [15:0] m;
      m = 16'h0000;
      unique case (a)
         ADDR_SHUTDOWN_GATING: m = MASK_SHUTDOWN_GATING;
         ADDR_OUT_EN_CAPSRC:   m = (FULL_INSTANCE != 0) ? MASK_OUT_EN_CAPSRC : 16'h81df;
         ADDR_DEAD_TIME:       m = (FULL_INSTANCE != 0) ? MASK_DEAD_TIME : 16'h0000;
         ADDR_MODE_POLARITY:   m = (FULL_INSTANCE != 0) ? MASK_MODE_POLARITY : MASK_MODE_POL_SMALL;
         default:              m = 16'h0000;
      endcase
      return m;
   endfunction : wmask

   // pin drive from raw pwm, polarity and shutdown state
   function automatic logic [1:0] drive(input logic act, input logic pol, input logic [1:0] pss,
                                        input logic shut, input logic en);
      logic [1:0] r;  // {oe, level}
      r = 2'h0;
      if (!en) r = 2'h0;
      else if (shut) begin
         if (pss == PSS_ACTIVE) r = {1'b1, ~pol};
         else if (pss == PSS_INACTIVE) r = {1'b1, pol};
         else r = 2'h0;
      end else r = {1'b1, act ^ pol};
      return r;
   endfunction : drive

   logic [7:0] src_raw;
   logic       req, sel_cap, gate_in, pwr_a, pwr_b;
   logic [5:0] act;

   assign src_raw = {output_fault_b, output_fault_a,
                     (CELL_SEL == 1) ? logic_cell_one_out : (CELL_SEL == 2) ? logic_cell_two_out : 1'b0,
                     2'b00, cmp_out};

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [15:0] m;
      m = 16'h0000;
      st_next = st_reg;
      st_next.s1 = {logic_cell_two_out, logic_cell_one_out, capture_input_pin, src_raw};
      st_next.s2 = st_reg.s1;
      // shutdown request from synchronised sources in slots 0-2 and 5-7 (3 and 4 tied low), or the software force
      req = |(st_reg.s2[7:0] & st_reg.sdg[7:0]) | st_reg.sdg[BIT_SW_FORCE];
      // register write
      if (reg_wr) begin
         m = wmask(reg_addr);
         unique case (reg_addr)
            ADDR_SHUTDOWN_GATING: st_next.sdg = reg_wdata & m;
            ADDR_OUT_EN_CAPSRC:   st_next.oec = reg_wdata & m;
            ADDR_DEAD_TIME:       st_next.dtc = reg_wdata & m;
            ADDR_MODE_POLARITY:   st_next.mpc = reg_wdata & m;
            ADDR_STATUS: begin
               if (reg_wdata[BIT_ST_GATE_ARM]) st_next.arm = 1'b1;
               if (reg_wdata[BIT_ST_SHUTDOWN]) st_next.sd = SCOC_RUN;
            end
            default: ;
         endcase
      end
      // output enable sync
      if (!st_reg.oec[BIT_OE_SYNC] || tb_rollover)
         st_next.oe_live = st_reg.oec[LSB_OUT_EN +: 6];
      // shutdown machine
      unique case (st_reg.sd)
         SCOC_RUN: if (req) st_next.sd = st_reg.sdg[BIT_GATE_MODE] ? SCOC_PEND : SCOC_SHUT;
         SCOC_PEND: if (tb_rollover) st_next.sd = SCOC_SHUT;
         SCOC_SHUT: if (st_reg.sdg[BIT_RESTART_EN] && !req && tb_rollover) st_next.sd = SCOC_RUN;
         default: st_next.sd = SCOC_RUN;
      endcase
      if (req && st_reg.sd == SCOC_SHUT) st_next.sd = SCOC_SHUT;   // set wins over clear
      // capture gating
      gate_in = req;
      st_next.gate_d = gate_in;
      unique case (st_reg.oec[LSB_CAP_GATE +: 2])
         GATE_LEVEL: st_next.cap_dis = ~gate_in;
         GATE_RISE: if (st_reg.arm && gate_in && !st_reg.gate_d) begin
            st_next.cap_dis = 1'b0;
            st_next.arm = 1'b0;
         end
         GATE_FALL: if (st_reg.arm && !gate_in && st_reg.gate_d) begin
            st_next.cap_dis = 1'b1;
            st_next.arm = 1'b0;
         end
         default: ;
      endcase
      // capture source
      unique case (st_reg.oec[LSB_CAP_SRC +: 3])
         3'h0: sel_cap = st_reg.s2[8];
         3'h1: sel_cap = st_reg.s2[0];
         3'h2: sel_cap = st_reg.s2[1];
         3'h3: sel_cap = st_reg.s2[2];
         3'h4: sel_cap = st_reg.s2[9];
         3'h5: sel_cap = st_reg.s2[10];
         default: sel_cap = 1'b0;
      endcase
      st_next.cap_sig = sel_cap & ~st_reg.cap_dis;
      // aux output
      unique case (st_reg.oec[LSB_AUX_SEL +: 2])
         AUX_OFF:      st_next.aux = 1'b0;
         AUX_ROLLOVER: st_next.aux = tb_rollover;
         AUX_MODE_SIG: st_next.aux = mode_aux_sig;
         AUX_EVENT:    st_next.aux = cap_cmp_event & ~timer_mode;
         default:      st_next.aux = 1'b0;
      endcase
      // trigger hold of outputs
      if (!trigger_mode_enable) st_next.trig_seen = 1'b0;
      else if (timer_triggered) st_next.trig_seen = 1'b1;
      // output steering by mode
      pwr_a = pwm_a;
      pwr_b = pwm_b;
      unique case (st_reg.mpc[LSB_OUT_MODE +: 3])
         OM_PUSH_PULL:   act = {4'h0, pwr_b, pwr_a};
         OM_HALF_BRIDGE: act = {4'h0, ~pwr_a, pwr_a};
         OM_BDC_REV:     act = {4'h0, pwr_a, 1'b1};
         OM_BDC_FWD:     act = {4'h0, 1'b1, pwr_a};
         OM_SCAN:        act = {6{pwr_a}};
         default:        act = {6{pwr_a}};
      endcase
      for (int i = 0; i < 6; i++) begin
         logic [1:0] d;
         d = drive(act[i],
                   (i % 2 == 0) ? st_reg.mpc[BIT_POL_ACE] : st_reg.mpc[BIT_POL_BDF],
                   (i % 2 == 0) ? st_reg.mpc[LSB_PSS_ACE +: 2] : st_reg.mpc[LSB_PSS_BDF +: 2],
                   st_reg.sd == SCOC_SHUT,
                   st_reg.oe_live[i] &&
                   !(st_reg.mpc[BIT_OE_TRIG] && trigger_mode_enable && !st_reg.trig_seen));
         st_next.pin_oe[i]  = d[1];
         st_next.pin_out[i] = d[0];
      end
      // read data
      st_next.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_SHUTDOWN_GATING: st_next.rdata = st_reg.sdg;
            ADDR_OUT_EN_CAPSRC:   st_next.rdata = st_reg.oec;
            ADDR_DEAD_TIME:       st_next.rdata = st_reg.dtc;
            ADDR_MODE_POLARITY:   st_next.rdata = st_reg.mpc;
            ADDR_STATUS:          st_next.rdata = {11'h000, st_reg.sd == SCOC_SHUT, 1'b0,
                                                   st_reg.cap_dis, 2'h0};
            default:              st_next.rdata = 16'h0000;
         endcase
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{sdg: RST_SHUTDOWN_GATING, oec: RST_OUT_EN_CAPSRC,
                     dtc: RST_DEAD_TIME, mpc: RST_MODE_POLARITY,
                     oe_live: 6'h01, sd: SCOC_RUN, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata             = st_reg.rdata;
   assign pin_out               = st_reg.pin_out;
   assign pin_oe                = st_reg.pin_oe;
   assign aux_out               = st_reg.aux;
   assign capture_signal        = st_reg.cap_sig;
   assign capture_disable_flag  = st_reg.cap_dis;
   assign shutdown_event_flag   = (st_reg.sd == SCOC_SHUT);
   assign dead_time_count       = st_reg.dtc[5:0];
   assign one_shot_extend_count = st_reg.mpc[LSB_OS_CNT +: 3];
   assign output_mode_select    = st_reg.mpc[LSB_OUT_MODE +: 3];

   // ************************************************************
   // checks
   // ************************************************************
   property p_gate_delay;
      @(posedge clk) disable iff (!rst_n)
      (st_reg.sd == SCOC_PEND && !tb_rollover) |=> st_reg.sd != SCOC_SHUT;
   endproperty
   a_gate_delay: assert property (p_gate_delay) else $error("shutdown before rollover");
   property p_immediate;
      @(posedge clk) disable iff (!rst_n)
      (st_reg.sd == SCOC_RUN && st_reg.sdg[BIT_SW_FORCE] && !st_reg.sdg[BIT_GATE_MODE]) |=> shutdown_event_flag;
   endproperty
   a_immediate: assert property (p_immediate) else $error("forced shutdown late");
   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      (shutdown_event_flag && !st_reg.sdg[BIT_RESTART_EN] && !(reg_wr && reg_addr == ADDR_STATUS))
      |=> shutdown_event_flag;
   endproperty
   a_hold: assert property (p_hold) else $error("shutdown cleared without software");
   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      (shutdown_event_flag && st_reg.sdg[BIT_RESTART_EN] && !req && tb_rollover) |=> !shutdown_event_flag;
   endproperty
   a_restart: assert property (p_restart) else $error("no auto restart");
   property p_rdzero;
      @(posedge clk) disable iff (!rst_n)
      reg_rd |=> (reg_rdata & ~wmask($past(reg_addr)) & 16'hffeb) == 16'h0000;
   endproperty
   a_rdzero: assert property (p_rdzero) else $error("reserved bit read nonzero");
   property p_oesync;
      @(posedge clk) disable iff (!rst_n)
      (st_reg.oec[BIT_OE_SYNC] && !tb_rollover) |=> $stable(st_reg.oe_live);
   endproperty
   a_oesync: assert property (p_oesync) else $error("enable changed off rollover");
   property p_capdis;
      @(posedge clk) disable iff (!rst_n)
      capture_disable_flag |=> !capture_signal;
   endproperty
   a_capdis: assert property (p_capdis) else $error("capture while disabled");
   property p_offpin;
      @(posedge clk) disable iff (!rst_n)
      !st_reg.oe_live[0] |=> !pin_oe[0];
   endproperty
   a_offpin: assert property (p_offpin) else $error("released pin driven");
   c_shut:    cover property (@(posedge clk) disable iff (!rst_n) $rose(shutdown_event_flag));
   c_restart: cover property (@(posedge clk) disable iff (!rst_n) $fell(shutdown_event_flag));
   c_gate:    cover property (@(posedge clk) disable iff (!rst_n) $rose(capture_disable_flag));
endmodule : scoc_top

// *** design/scoc_pkg.sv ***
package scoc_pkg;
   // ************************************************************
   // register indices (16-bit registers on a plain port)
   // ************************************************************
   localparam logic [2:0]  ADDR_SHUTDOWN_GATING   = 3'h0;
   localparam logic [2:0]  ADDR_OUT_EN_CAPSRC     = 3'h1;
   localparam logic [2:0]  ADDR_DEAD_TIME         = 3'h2;
   localparam logic [2:0]  ADDR_MODE_POLARITY     = 3'h3;
   localparam logic [2:0]  ADDR_STATUS            = 3'h4;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BIT_RESTART_EN   = 15;
   localparam int BIT_GATE_MODE    = 14;
   localparam int BIT_SW_FORCE     = 12;
   localparam int BIT_OE_SYNC      = 15;
   localparam int LSB_OUT_EN       = 8;
   localparam int LSB_CAP_GATE     = 6;
   localparam int LSB_AUX_SEL      = 3;
   localparam int LSB_CAP_SRC      = 0;
   localparam int BIT_OE_TRIG      = 15;
   localparam int LSB_OS_CNT       = 12;
   localparam int LSB_OUT_MODE     = 8;
   localparam int BIT_POL_ACE      = 5;
   localparam int BIT_POL_BDF      = 4;
   localparam int LSB_PSS_ACE      = 2;
   localparam int LSB_PSS_BDF      = 0;
   localparam int BIT_ST_SHUTDOWN  = 4;
   localparam int BIT_ST_CAP_DIS   = 2;
   localparam int BIT_ST_GATE_ARM  = 10;

   // ************************************************************
   // writable masks and reset values
   // ************************************************************
   localparam logic [15:0] MASK_SHUTDOWN_GATING   = 16'hd0ff;
   localparam logic [15:0] MASK_OUT_EN_CAPSRC     = 16'hbfdf;
   localparam logic [15:0] MASK_DEAD_TIME         = 16'h003f;
   localparam logic [15:0] MASK_MODE_POLARITY     = 16'hf73f;
   localparam logic [15:0] MASK_MODE_POL_SMALL    = 16'hf02c;
   localparam logic [15:0] RST_SHUTDOWN_GATING    = 16'h0000;
   localparam logic [15:0] RST_OUT_EN_CAPSRC      = 16'h0100;
   localparam logic [15:0] RST_DEAD_TIME          = 16'h0000;
   localparam logic [15:0] RST_MODE_POLARITY      = 16'h0000;

   // ************************************************************
   // encodings
   // ************************************************************
   localparam logic [1:0]  GATE_LEVEL     = 2'h0;
   localparam logic [1:0]  GATE_RISE      = 2'h1;
   localparam logic [1:0]  GATE_FALL      = 2'h2;
   localparam logic [1:0]  AUX_OFF        = 2'h0;
   localparam logic [1:0]  AUX_ROLLOVER   = 2'h1;
   localparam logic [1:0]  AUX_MODE_SIG   = 2'h2;
   localparam logic [1:0]  AUX_EVENT      = 2'h3;
   localparam logic [1:0]  PSS_ACTIVE     = 2'h3;
   localparam logic [1:0]  PSS_INACTIVE   = 2'h2;
   localparam logic [2:0]  OM_STEER       = 3'h0;
   localparam logic [2:0]  OM_PUSH_PULL   = 3'h1;
   localparam logic [2:0]  OM_HALF_BRIDGE = 3'h2;
   localparam logic [2:0]  OM_BDC_REV     = 3'h4;
   localparam logic [2:0]  OM_BDC_FWD     = 3'h5;
   localparam logic [2:0]  OM_SCAN        = 3'h6;

   typedef enum logic [2:0] {
      SCOC_RUN  = 3'b001,
      SCOC_PEND = 3'b010,
      SCOC_SHUT = 3'b100
   } scoc_sd_e;
endpackage : scoc_pkg

// *** testbench/scoc_far_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// far side: gating sources and power switch pins
// ************************************************************
module scoc_far_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // requests from the bench, slot 8 is the capture pin
   input  wire logic [8:0] src_req,
   // pins from the block
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   // gating sources
   output logic      [2:0] cmp_out,
   output logic            cell_one,
   output logic            cell_two,
   output logic            fault_a,
   output logic            fault_b,
   output logic            cap_pin,
   // resolved pin levels
   output logic      [5:0] pin_level
);
   logic [8:0] src_reg;
   logic [5:0] last_reg;

   // sources move only just after a clock edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_reg  <= 9'h000;
         last_reg <= 6'h00;
      end else begin
         src_reg  <= src_req;
         last_reg <= pin_level;
      end
   end

   // slots 0-2 comparators, 5 cell one, 6-7 faults; cell two rides unused slot 4
   assign cmp_out  = src_reg[2:0];
   assign cell_one = src_reg[5];
   assign cell_two = src_reg[4];
   assign fault_a  = src_reg[6];
   assign fault_b  = src_reg[7];
   assign cap_pin  = src_reg[8];
   // a released pin floats, so it shows the inverse of its last level
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~last_reg);
endmodule : scoc_far_model

// *** testbench/ccp_shutdown_output_control_test.sv ***
`timescale 1ns/1ps
// ************************************************************
// register level bench for the shutdown and output control slice
// ************************************************************
module ccp_shutdown_output_control_test;
   import scoc_pkg::*;
   logic        clk, rst_n, reg_wr, reg_rd, tb_rollover, trigger_mode_enable, timer_triggered;
   logic        cap_cmp_event, timer_mode, mode_aux_sig, pwm_a, pwm_b, cell1, cell2, fa, fb, cap_pin;
   logic        aux_out, capture_signal, capture_disable_flag, shutdown_event_flag;
   logic [2:0]  reg_addr, cmp_out, one_shot_extend_count, output_mode_select;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [5:0]  pin_out, pin_oe, pin_level, dead_time_count;
   logic [8:0]  src_req;
   logic [4:0]  e;
   int          n_errors, compares;
   logic [15:0] rstv[4] = '{RST_SHUTDOWN_GATING, RST_OUT_EN_CAPSRC, RST_DEAD_TIME, RST_MODE_POLARITY};
   logic [15:0] mskv[4] = '{MASK_SHUTDOWN_GATING, MASK_OUT_EN_CAPSRC, MASK_DEAD_TIME, MASK_MODE_POLARITY};
   logic [4:0]  pss_tab[5] = '{5'h0f, 5'h1e, 5'h1b, 5'h0a, 5'h00}; // pol, state, oe, level
   int          cs_idx[6] = '{8, 0, 1, 2, 5, 4};

   scoc_top u_scoc_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tb_rollover(tb_rollover), .trigger_mode_enable(trigger_mode_enable),
      .timer_triggered(timer_triggered), .cap_cmp_event(cap_cmp_event), .timer_mode(timer_mode),
      .mode_aux_sig(mode_aux_sig), .pwm_a(pwm_a), .pwm_b(pwm_b), .cmp_out(cmp_out), .logic_cell_one_out(cell1),
      .logic_cell_two_out(cell2), .output_fault_a(fa), .output_fault_b(fb), .capture_input_pin(cap_pin),
      .pin_out(pin_out), .pin_oe(pin_oe), .aux_out(aux_out), .capture_signal(capture_signal),
      .capture_disable_flag(capture_disable_flag), .shutdown_event_flag(shutdown_event_flag),
      .dead_time_count(dead_time_count), .one_shot_extend_count(one_shot_extend_count),
      .output_mode_select(output_mode_select));
   scoc_far_model u_scoc_far_model (.clk(clk), .rst_n(rst_n), .src_req(src_req), .pin_out(pin_out),
      .pin_oe(pin_oe), .cmp_out(cmp_out), .cell_one(cell1), .cell_two(cell2), .fault_a(fa), .fault_b(fb),
      .cap_pin(cap_pin), .pin_level(pin_level));

   // 250 MHz clock
   always #2 clk = ~clk;

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic final_report();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic pulse(input int w);
      @(posedge clk);
      if (w == 0) tb_rollover <= 1'b1;
      else cap_cmp_event <= 1'b1;
      @(posedge clk);
      tb_rollover   <= 1'b0;
      cap_cmp_event <= 1'b0;
   endtask : pulse

   function automatic logic sig(input int w);
      case (w)
         0: return shutdown_event_flag;
         1: return aux_out;
         2: return capture_disable_flag;
         3: return pin_oe[0];
         default: return capture_signal;
      endcase
   endfunction : sig

   // bounded wait for one output to reach a level
   task automatic wait_for(input int w, input logic v, input int bound);
      for (int i = 0; i < bound; i++) begin
         tick(1);
         if (sig(w) === v) break;
      end
      chk({15'h0, sig(w)}, {15'h0, v});
      if (sig(w) !== v) final_report();
   endtask : wait_for

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {clk, rst_n, reg_wr, reg_rd, tb_rollover, trigger_mode_enable, timer_triggered} = '0;
      {cap_cmp_event, timer_mode, mode_aux_sig, pwm_a, pwm_b, reg_addr, reg_wdata, src_req} = '0;
      {n_errors, compares} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, writable masks, unmapped index
      for (int i = 0; i < 4; i++) begin
         rd(3'(i), rv);
         chk(rv, rstv[i]);
         wr(3'(i), 16'hffff);
         rd(3'(i), rv);
         chk(rv, mskv[i]);
         wr(3'(i), rstv[i]);
      end
      rd(3'h5, rv);
      chk(rv, 16'h0000);
      wr(ADDR_STATUS, 16'h0010);
      wait_for(0, 1'b0, 8);
      // forced shutdown, pin states and polarity, manual clear
      for (int i = 0; i < 5; i++) begin
         e = pss_tab[i];
         wr(ADDR_MODE_POLARITY, {10'h0, e[4], 1'b0, e[3:2], 2'b00});
         wr(ADDR_SHUTDOWN_GATING, 16'h1000);
         wait_for(0, 1'b1, 8);
         tick(3);
         chk({15'h0, pin_oe[0]}, {15'h0, e[1]});
         if (e[1]) chk({15'h0, pin_level[0]}, {15'h0, e[0]});
         wr(ADDR_SHUTDOWN_GATING, 16'h0000);
         tick(6);
         rd(ADDR_STATUS, rv);
         chk(rv & 16'h0010, 16'h0010);
         wr(ADDR_STATUS, 16'h0010);
         wait_for(0, 1'b0, 8);
      end
      wr(ADDR_MODE_POLARITY, 16'h0000);
      // gate mode holds the forced event until rollover
      wr(ADDR_SHUTDOWN_GATING, 16'h5000);
      tick(10);
      chk({15'h0, shutdown_event_flag}, 16'h0000);
      pulse(0);
      wait_for(0, 1'b1, 8);
      wr(ADDR_SHUTDOWN_GATING, 16'h0000);
      wr(ADDR_STATUS, 16'h0010);
      wait_for(0, 1'b0, 8);
      // each source slot, enabled alone and disabled among all others
      for (int n = 0; n < 8; n++) begin
         src_req <= 9'(1 << n);
         wr(ADDR_SHUTDOWN_GATING, 16'h00ff ^ 16'(1 << n));
         tick(8);
         chk({15'h0, shutdown_event_flag}, 16'h0000);
         wr(ADDR_SHUTDOWN_GATING, 16'(1 << n));
         tick(8);
         chk({15'h0, shutdown_event_flag}, {15'h0, n != 3 && n != 4});
         src_req <= 9'h000;
         wr(ADDR_SHUTDOWN_GATING, 16'h0000);
         wr(ADDR_STATUS, 16'h0010);
         wait_for(0, 1'b0, 8);
      end
      // automatic restart at the next period once the source is gone
      wr(ADDR_SHUTDOWN_GATING, 16'h8001);
      src_req <= 9'h001;
      wait_for(0, 1'b1, 8);
      src_req <= 9'h000;
      tick(10);
      chk({15'h0, shutdown_event_flag}, 16'h0001);
      pulse(0);
      wait_for(0, 1'b0, 8);
      wr(ADDR_SHUTDOWN_GATING, 16'h0000);
      // pin enable, deferred and immediate updates
      pwm_a <= 1'b1;
      wait_for(3, 1'b1, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h8000);
      tick(6);
      chk({15'h0, pin_oe[0]}, 16'h0001);
      pulse(0);
      wait_for(3, 1'b0, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h0100);
      wait_for(3, 1'b1, 8);
      // pins held undriven until triggered, only in triggered operation
      trigger_mode_enable <= 1'b1;
      wr(ADDR_MODE_POLARITY, 16'h8000);
      wait_for(3, 1'b0, 8);
      timer_triggered <= 1'b1;
      wait_for(3, 1'b1, 8);
      {trigger_mode_enable, timer_triggered} <= 2'b00;
      tick(6);
      chk({15'h0, pin_oe[0]}, 16'h0001);
      // exported fields over every output mode
      for (int m = 0; m < 7; m++) begin
         if (m == 3) continue;
         wr(ADDR_MODE_POLARITY, {1'b0, 3'(m + 1), 1'b0, 3'(m), 8'h00});
         wr(ADDR_DEAD_TIME, 16'(m * 9 + 9));
         tick(2);
         chk({13'h0, output_mode_select}, 16'(m));
         chk({13'h0, one_shot_extend_count}, 16'(m + 1));
         chk({10'h0, dead_time_count}, 16'(m * 9 + 9));
      end
      // capture gating: level, armed rising, armed falling
      wr(ADDR_OUT_EN_CAPSRC, 16'h0100);
      wait_for(2, 1'b1, 8);
      wr(ADDR_SHUTDOWN_GATING, 16'h1000);
      wait_for(2, 1'b0, 8);
      wr(ADDR_SHUTDOWN_GATING, 16'h0000);
      wait_for(2, 1'b1, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h0140);
      wr(ADDR_STATUS, 16'h0400);
      wr(ADDR_SHUTDOWN_GATING, 16'h1000);
      wait_for(2, 1'b0, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h0180);
      wr(ADDR_STATUS, 16'h0400);
      wr(ADDR_SHUTDOWN_GATING, 16'h0000);
      wait_for(2, 1'b1, 8);
      // capture source follows the selected input while gate is open
      wr(ADDR_SHUTDOWN_GATING, 16'h1000);
      for (int s = 0; s < 6; s++) begin
         wr(ADDR_OUT_EN_CAPSRC, 16'h0100 | 16'(s));
         src_req <= 9'(1 << cs_idx[s]);
         wait_for(4, 1'b1, 10);
         src_req <= 9'h000;
         wait_for(4, 1'b0, 10);
      end
      wr(ADDR_SHUTDOWN_GATING, 16'h0000);
      wr(ADDR_STATUS, 16'h0010);
      // auxiliary output selections
      mode_aux_sig <= 1'b1;
      wr(ADDR_OUT_EN_CAPSRC, 16'h0110);
      wait_for(1, 1'b1, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h0100);
      wait_for(1, 1'b0, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h0108);
      pulse(0);
      #1 chk({15'h0, aux_out}, 16'h0001);
      wait_for(1, 1'b0, 8);
      wr(ADDR_OUT_EN_CAPSRC, 16'h0118);
      pulse(1);
      #1 chk({15'h0, aux_out}, 16'h0001);
      final_report();
   end
endmodule : ccp_shutdown_output_control_test
